// file: rtl/basic_up_down_timer_pkg.sv
package basic_up_down_timer_pkg;

  localparam int DEFAULT_COUNT_WIDTH = 32;
  localparam int BUS_ADDR_WIDTH      = 5;
  localparam int BUS_DATA_WIDTH      = 32;
  localparam int BUS_SEL_WIDTH       = 4;
  localparam int PRESCALE_WIDTH      = 16;

  localparam logic [BUS_ADDR_WIDTH-1:0] OFS_COUNT   = 5'h00;
  localparam logic [BUS_ADDR_WIDTH-1:0] OFS_RESTART = 5'h04;
  localparam logic [BUS_ADDR_WIDTH-1:0] OFS_STATUS  = 5'h08;
  localparam logic [BUS_ADDR_WIDTH-1:0] OFS_IRQ_EN  = 5'h0C;
  localparam logic [BUS_ADDR_WIDTH-1:0] OFS_CONTROL = 5'h10;

  // Bit 0 of the status and interrupt-enable words.
  localparam int EVENT_BIT = 0;

  localparam logic [31:0] RESET_COUNT   = 32'h0000_0000;
  localparam logic [31:0] RESET_RESTART = 32'h0000_0000;
  localparam logic        RESET_EVENT   = 1'b0;
  localparam logic        RESET_IRQ_EN  = 1'b0;

  // Control word layout, most significant field first.
  typedef struct packed {
    logic [PRESCALE_WIDTH-1:0] prescale;
    logic [7:0]                rsvdHigh;
    logic                      halt;
    logic                      reload;
    logic                      start;
    logic                      softReset;
    logic                      autoRestart;
    logic                      countUp;
    logic                      rsvdLow;
    logic                      enable;
  } control_s;

  localparam control_s RESET_CONTROL = 32'h0000_0000;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic                      cyc;
    logic                      stb;
    logic                      we;
    logic [BUS_ADDR_WIDTH-1:0] adr;
    logic [BUS_SEL_WIDTH-1:0]  sel;
    logic [BUS_DATA_WIDTH-1:0] dat;
  } wb_req_s;

endpackage

// file: rtl/basic_up_down_timer.sv
`timescale 1ns/1ps
// Summary of operation
// - Count register holds live counter, upper bits zero.
// - Low-byte count reads return live count and take a snapshot; other byte reads return it.
// - Preload value reloads counter on automatic restart.
// - Preload width equals counter; upper bits zero.
// - Status bit 0 sets at limit, writing 1 clears.
// - Restart mode pulses event; otherwise level held.
// - Enable bit 0 gates event onto interrupt.
// - Prescaler pulses count enable every setting+1 clocks.
// - Prescaler makes enables, never a derived clock.
// - Halt stops counter and resets divider.
// - Clearing halt resumes from held value.
// - Reload bit reloads counter while running.
// - Reload ignored once start reads zero.
// - Start resets divider, counts, clears interrupts.
// - Auto restart reloads; otherwise enters done state.
// - Direction bit; saturate at all ones or zero.
// - Block reset is main reset OR soft reset.
module basic_up_down_timer #(
  parameter int COUNT_WIDTH = basic_up_down_timer_pkg::DEFAULT_COUNT_WIDTH
) (
  input  logic                            ref_clk,
  input  logic                            reset,
  input  basic_up_down_timer_pkg::wb_req_s wbReq,
  output logic                            wbAck,
  output logic [31:0]                     wbDatO,
  output logic                            timerIrq
);
  import basic_up_down_timer_pkg::*;

  if (COUNT_WIDTH != 16 && COUNT_WIDTH != 32) begin : g_bad_width
    $error("COUNT_WIDTH must be 16 or 32");
  end

  logic                      softRst;
  logic                      blockReset;
  control_s                  ctrl;
  control_s                  ctrlWord;
  control_s                  next_ctrl;
  logic [COUNT_WIDTH-1:0]    count;
  logic [COUNT_WIDTH-1:0]    countHold;
  logic [COUNT_WIDTH-1:0]    restartValue;
  logic [COUNT_WIDTH-1:0]    next_count;
  logic [PRESCALE_WIDTH-1:0] prescaleCount;
  logic [PRESCALE_WIDTH-1:0] next_prescale;
  logic                      eventFlag;
  logic                      next_event;
  logic                      irqEnable;
  logic                      next_start;

  // The soft reset flop is a register, so the combined reset is glitch free.
  assign blockReset = reset | softRst;

  // Bus decode.
  wire        busReq    = wbReq.cyc & wbReq.stb;
  wire        dataPhase = busReq & ~wbAck;
  wire        writeNow  = busReq & wbReq.we & wbAck;
  wire        selCount  = (wbReq.adr == OFS_COUNT);
  wire        selRest   = (wbReq.adr == OFS_RESTART);
  wire        selStat   = (wbReq.adr == OFS_STATUS);
  wire        selIrqEn  = (wbReq.adr == OFS_IRQ_EN);
  wire        selCtrl   = (wbReq.adr == OFS_CONTROL);
  wire        wrCount   = writeNow & selCount;
  wire        wrRest    = writeNow & selRest;
  wire        wrStat    = writeNow & selStat;
  wire        wrIrqEn   = writeNow & selIrqEn;
  wire        wrCtrl    = writeNow & selCtrl;
  wire [31:0] byteMask  = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}},
                           {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};

  // Bits above the counter width are dropped here, so writes there vanish.
  wire [31:0] countWord = (32'(count) & ~byteMask) | (wbReq.dat & byteMask);
  wire [31:0] restWord  = (32'(restartValue) & ~byteMask) |
                          (wbReq.dat & byteMask);
  assign ctrlWord = (ctrl & ~byteMask) | (wbReq.dat & byteMask);

  wire clearEvent = wrStat & wbReq.sel[0] & wbReq.dat[EVENT_BIT];
  wire newIrqEn   = wbReq.sel[0] ? wbReq.dat[EVENT_BIT] : irqEnable;

  // Counting.
  wire running   = ctrl.enable & ctrl.start & ~ctrl.halt;
  wire tick      = running & (prescaleCount == ctrl.prescale);
  wire atLimit   = ctrl.countUp ? (count == '1) : (count == '0);
  wire limitHit  = tick & atLimit;
  wire startRise = wrCtrl & ctrlWord.start & ~ctrl.start;
  wire reloadReq = wrCtrl & ctrlWord.reload & ctrl.start;
  wire [COUNT_WIDTH-1:0] stepped = ctrl.countUp ?
                                   count + COUNT_WIDTH'(1) :
                                   count - COUNT_WIDTH'(1);

  // Firmware writes win over counting; halted state keeps the value.
  assign next_count = wrCount   ? countWord[COUNT_WIDTH-1:0] :
                      reloadReq ? restartValue :
                      limitHit  ? (ctrl.autoRestart ? restartValue
                                                    : count) :
                      tick      ? stepped : count;

  // Divider is cleared while stopped, on start and after each enable.
  assign next_prescale = (~running | startRise | tick) ?
                         '0 : prescaleCount + PRESCALE_WIDTH'(1);

  assign next_start = startRise ? 1'b1 :
                      (limitHit & ~ctrl.autoRestart) ? 1'b0 :
                      wrCtrl ? ctrlWord.start : ctrl.start;

  // Set wins over a clear in the same cycle; restart mode self clears.
  assign next_event = startRise ? 1'b0 :
                      limitHit ? 1'b1 :
                      (ctrl.autoRestart | clearEvent) ? 1'b0 :
                      eventFlag;

  always_comb begin
    next_ctrl           = wrCtrl ? ctrlWord : ctrl;
    next_ctrl.rsvdHigh  = '0;
    next_ctrl.rsvdLow   = 1'b0;
    next_ctrl.reload    = 1'b0;
    next_ctrl.softReset = 1'b0;
    next_ctrl.start     = next_start;
  end

  // A read of the low byte takes the snapshot; other bytes read it back.
  wire [31:0] countRead = wbReq.sel[0] ? 32'(count) : 32'(countHold);
  wire [31:0] readWord  =
    selCount ? countRead :
    selRest  ? 32'(restartValue) :
    selStat  ? 32'(eventFlag) :
    selIrqEn ? 32'(irqEnable) :
    selCtrl  ? 32'(ctrl) : 32'h0000_0000;
  wire takeHold = dataPhase & ~wbReq.we & selCount & wbReq.sel[0];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      softRst <= 1'b0;
      wbAck   <= 1'b0;
      wbDatO  <= 32'h0000_0000;
    end else begin
      softRst <= wrCtrl & ctrlWord.softReset;
      wbAck   <= dataPhase;
      wbDatO  <= (dataPhase & ~wbReq.we) ? readWord : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or posedge blockReset) begin
    if (blockReset) begin
      ctrl          <= RESET_CONTROL;
      count         <= RESET_COUNT[COUNT_WIDTH-1:0];
      countHold     <= RESET_COUNT[COUNT_WIDTH-1:0];
      restartValue  <= RESET_RESTART[COUNT_WIDTH-1:0];
      prescaleCount <= '0;
      eventFlag     <= RESET_EVENT;
      irqEnable     <= RESET_IRQ_EN;
      timerIrq      <= 1'b0;
    end else begin
      ctrl          <= next_ctrl;
      count         <= next_count;
      countHold     <= takeHold ? count : countHold;
      restartValue  <= wrRest ? restWord[COUNT_WIDTH-1:0]
                              : restartValue;
      prescaleCount <= next_prescale;
      eventFlag     <= next_event;
      irqEnable     <= wrIrqEn ? newIrqEn : irqEnable;
      timerIrq      <= eventFlag & irqEnable;
    end
  end

endmodule // basic_up_down_timer

// file: verification/basic_up_down_timer_asserts.sv
`timescale 1ns/1ps
module basic_up_down_timer_asserts #(
  parameter int COUNT_WIDTH = 32
) (
  input logic                             ref_clk,
  input logic                             reset,
  input basic_up_down_timer_pkg::wb_req_s wbReq,
  input logic                             wbAck,
  input logic [31:0]                      wbDatO,
  input logic                             timerIrq
);
  import basic_up_down_timer_pkg::*;
  wire rdAck  = wbAck & ~wbReq.we;
  wire maskWr = wbAck & wbReq.we & wbReq.sel[0] & (wbReq.adr == OFS_IRQ_EN)
                & ~wbReq.dat[0];
  wire softWr = wbAck & wbReq.we & wbReq.sel[0] & (wbReq.adr == OFS_CONTROL)
                & wbReq.dat[4];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  ack_answer_a: assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck)
    else $error("request not answered");
  ack_single_a: assert property (wbAck |=> !wbAck)
    else $error("ack held too long");
  data_idle_a: assert property (!wbAck |-> wbDatO == 32'h0)
    else $error("read data outside ack");
  count_width_a: assert property (rdAck && wbReq.adr < OFS_STATUS |->
    (wbDatO >> COUNT_WIDTH) == 32'h0) else $error("upper count bits set");
  flag_width_a: assert property (rdAck && wbReq.adr[4:3] == 2'h1 |->
    wbDatO[31:1] == 31'h0) else $error("flag word bits set");
  ctrl_rsvd_a: assert property (rdAck && wbReq.adr == OFS_CONTROL |->
    wbDatO[15:8] == 8'h0 && !wbDatO[4]) else $error("control bits set");
  irq_mask_a: assert property (maskWr |-> ##2 !timerIrq)
    else $error("masked interrupt seen");
  soft_reset_a: assert property (softWr |-> ##2 !timerIrq)
    else $error("interrupt after soft reset");
  cover property (softWr);
  cover property (maskWr);
  cover property ($rose(timerIrq));
endmodule // basic_up_down_timer_asserts
bind basic_up_down_timer
  basic_up_down_timer_asserts #(.COUNT_WIDTH(COUNT_WIDTH))
  chk_u (.ref_clk(ref_clk), .reset(reset), .wbReq(wbReq), .wbAck(wbAck),
  .wbDatO(wbDatO), .timerIrq(timerIrq));

// file: verification/basic_up_down_timer_tb_top.sv
`timescale 1ns/1ps
module basic_up_down_timer_tb_top;
  import basic_up_down_timer_pkg::*;
  logic        ref_clk = 1'h0;
  logic        reset = 1'h1;
  wb_req_s     wbReq = '0;
  logic        wbAck;
  logic        timerIrq;
  logic [31:0] wbDatO;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          irqCycles = 0;
  basic_up_down_timer #(.COUNT_WIDTH(16)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .wbReq(wbReq),
    .wbAck(wbAck), .wbDatO(wbDatO), .timerIrq(timerIrq));
  initial forever #50 ref_clk = ~ref_clk;
  task automatic check(string w, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) mismatches++;
    if (seen !== exp)
      $display("unexpected %s expected %h seen %h", w, exp, seen);
  endtask
  task automatic acc(logic we, logic [4:0] a, logic [31:0] d,
                     logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge ref_clk);
    wbReq <= '{1'h1, 1'h1, we, a, s, d};
    do @(posedge ref_clk); while (wbAck !== 1'h1 && ++n < 50);
    if (n >= 50) mismatches++;
    if (!we) check($sformatf("reg %h", a), wbDatO, d);
    wbReq <= '0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'h0;
    for (int a = 0; a < 28; a += 4) acc(1'h0, a[4:0], 32'h0);
    acc(1'h1, OFS_RESTART, 32'hFFFF_ABCD);
    acc(1'h0, OFS_RESTART, 32'h0000_ABCD);
    $display("register test done");
    acc(1'h1, OFS_COUNT, 32'h1234_FFFD);
    acc(1'h1, OFS_IRQ_EN, 32'h1);
    acc(1'h1, OFS_CONTROL, 32'h0001_0025);
    repeat (20) @(posedge ref_clk);
    check("irq", timerIrq, 32'h1);
    acc(1'h0, OFS_COUNT, 32'h0000_FFFF);
    acc(1'h0, OFS_CONTROL, 32'h0001_0005);
    acc(1'h1, OFS_CONTROL, 32'h0001_0045);
    acc(1'h0, OFS_COUNT, 32'h0000_FFFF);
    acc(1'h1, OFS_IRQ_EN, 32'h0);
    acc(1'h1, OFS_STATUS, 32'h1);
    acc(1'h0, OFS_STATUS, 32'h0);
    $display("limit test done");
    acc(1'h1, OFS_COUNT, 32'h64);
    acc(1'h1, OFS_CONTROL, 32'h0003_0021);
    repeat (19) @(posedge ref_clk);
    acc(1'h1, OFS_CONTROL, 32'h0003_00A1);
    acc(1'h0, OFS_COUNT, 32'h5F);
    acc(1'h1, OFS_RESTART, 32'hC8);
    acc(1'h1, OFS_CONTROL, 32'h0003_0061);
    acc(1'h0, OFS_COUNT, 32'hC8);
    acc(1'h1, OFS_CONTROL, 32'h0);
    $display("prescale test done");
    acc(1'h1, OFS_COUNT, 32'hFF);
    acc(1'h1, OFS_CONTROL, 32'h25);
    acc(1'h0, OFS_COUNT, 32'h100, 4'h1);
    acc(1'h0, OFS_COUNT, 32'h100, 4'h2);
    acc(1'h1, OFS_CONTROL, 32'hA5);
    acc(1'h0, OFS_COUNT, 32'h108);
    acc(1'h1, OFS_CONTROL, 32'h25);
    acc(1'h0, OFS_COUNT, 32'h109);
    acc(1'h1, OFS_CONTROL, 32'h0);
    $display("snapshot test done");
    acc(1'h1, OFS_RESTART, 32'hFFFE);
    acc(1'h1, OFS_COUNT, 32'hFFFE);
    acc(1'h1, OFS_IRQ_EN, 32'h1);
    acc(1'h1, OFS_CONTROL, 32'h0001_002D);
    repeat (8) @(posedge ref_clk);
    repeat (40) begin
      @(posedge ref_clk);
      if (timerIrq === 1'h1) irqCycles++;
    end
    check("irq pulses", irqCycles, 32'hA);
    acc(1'h0, OFS_CONTROL, 32'h0001_002D);
    $display("restart test done");
    acc(1'h1, OFS_CONTROL, 32'h10);
    acc(1'h0, OFS_RESTART, 32'h0);
    acc(1'h0, OFS_COUNT, 32'h0);
    acc(1'h0, OFS_CONTROL, 32'h0);
    $display("soft reset test done");
    conclude();
  end
endmodule // basic_up_down_timer_tb_top
